// ---- hdl/pmath_pkg.sv ----
package pmath_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OPER = 8'h04;
  localparam logic [7:0] OFF_VAL_AB = 8'h08;
  localparam logic [7:0] OFF_VAL_CD = 8'h0C;
  localparam logic [7:0] OFF_RESULT = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h1C;

  // Control register fields.
  localparam int CTRL_CLR_OFF_BIT = 0;
  localparam int CTRL_DET_AFTER_BIT = 1;
  localparam int CTRL_AUTO_BIT = 2;
  localparam int CTRL_TYPE_LSB = 4;
  localparam int CTRL_SCAN_BIT = 8;
  localparam int CTRL_UNIT_LSB = 16;

  // Operator register fields.
  localparam int OPER_OP_LSB = 0;
  localparam int OPER_PRIO_LSB = 8;
  localparam int OPER_DEC_LSB = 16;
  localparam int OPER_SRC_LSB = 20;

  // Result register fields.
  localparam int RES_ZDIV_BIT = 16;
  localparam int RES_OVF_BIT = 17;
  localparam int RES_FLAG_BIT = 18;
  localparam int RES_BUSY_BIT = 19;

  // Interrupt status bits.
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ZDIV_BIT = 1;
  localparam int IRQ_OVF_BIT = 2;
  localparam int IRQ_FLAG_BIT = 3;
  localparam int IRQ_W = 4;

  // Reset values: all operators add, priorities high, medium, low in slot order.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] OPER_RST = 32'h0000_2400;
  localparam logic [31:0] VAL_RST = 32'h0000_0000;

  // Signed 16-bit saturation limits.
  localparam logic signed [15:0] SAT_POS = 16'sh7FFF;
  localparam logic signed [15:0] SAT_NEG = 16'sh8000;
  localparam logic signed [32:0] LIM_POS = 33'sh0_0000_7FFF;
  localparam logic signed [32:0] LIM_NEG = 33'sh1_FFFF_8000;

  // Bus transfer type bit that marks NONSEQ or SEQ.
  localparam int HTRANS_ACTIVE_BIT = 1;

  typedef enum logic [1:0] {
    OP_ADD = 2'b00,
    OP_SUB = 2'b01,
    OP_MUL = 2'b10,
    OP_DIV = 2'b11
  } operator_e;

  typedef enum logic [1:0] {
    ERR_ZDIV = 2'b00,
    ERR_OVF = 2'b01,
    ERR_EITHER = 2'b10,
    ERR_EITHER_ALT = 2'b11
  } err_type_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_STEP = 2'b01,
    S_DONE = 2'b10
  } state_e;

  typedef struct packed {
    logic [15:0] fourth;
    logic [15:0] third;
    logic [15:0] second;
    logic [15:0] first;
  } operands_s;

endpackage : pmath_pkg

// ---- hdl/pmath_top.sv ----
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Always four operands and three operators.
// - Each operator adds, subtracts, multiplies or divides.
// - Evaluate high, then medium, then low priority.
// - Round result to nearest integer.
// - Zero division or positive overflow gives 32767.
// - Negative overflow gives -32768.
// - Disabled output holds or clears, as configured.
// - Each execution updates zero-division and overflow bits.
// - Operand may come from another block's output.
// - Decimal places affect display only.
// - Detector bound to one unit by number.
// - Flag on zero division, overflow or either.
// - Auto reset makes flag follow current error.
// - Without auto reset, flag holds until cleared.
// - Detector order sets same or next scan.
// - No referenced unit keeps flag low.
module pmath_top #(
  parameter logic [7:0] UNIT_NUMBER = 8'h01
) (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic EN_IN,
  input wire logic SCAN_IN,
  input wire pmath_pkg::operands_s EXT_OPERAND_IN,
  input wire logic DET_EN_IN,
  input wire logic DET_CLR_IN,
  output logic [15:0] MATH_RESULT_OUT,
  output logic ERR_FLAG_OUT,
  output logic IRQ_OUT
);

  logic [31:0] ctrl_q, oper_q, ab_q, cd_q;
  logic [pmath_pkg::IRQ_W-1:0] ists_q, ists_d, ien_q;
  logic wr_pend_q;
  logic [7:0] waddr_q;
  logic [31:0] rdata_q;
  pmath_pkg::state_e state_q;
  logic [1:0] step_q;
  logic ran_q, zacc_q, oacc_q, zdiv_q, ovf_q, flag_q, irq_q;
  logic [2:0] done_q;
  logic signed [15:0] val_q [4];
  logic signed [15:0] result_q;

  // Bus decode. Only word transfers exist on this bus, so the size is not checked.
  wire active_w = HSEL_IN & HREADY_IN & HTRANS_IN[pmath_pkg::HTRANS_ACTIVE_BIT];
  wire [7:0] raddr_w = {HADDR_IN[7:2], 2'b00};
  wire wr_now_w = wr_pend_q;
  wire fwd_w = wr_pend_q & (waddr_q == raddr_w);
  wire scan_req_w = wr_now_w & (waddr_q == pmath_pkg::OFF_CTRL) &
                    HWDATA_IN[pmath_pkg::CTRL_SCAN_BIT];
  wire go_w = (SCAN_IN | scan_req_w) & (state_q == pmath_pkg::S_IDLE);

  // Configuration fields. The decimal setting is stored and read back only.
  wire clr_off_w = ctrl_q[pmath_pkg::CTRL_CLR_OFF_BIT];
  wire det_after_w = ctrl_q[pmath_pkg::CTRL_DET_AFTER_BIT];
  wire auto_w = ctrl_q[pmath_pkg::CTRL_AUTO_BIT];
  wire [1:0] etype_w = ctrl_q[pmath_pkg::CTRL_TYPE_LSB +: 2];
  wire [7:0] watched_unit_number = ctrl_q[pmath_pkg::CTRL_UNIT_LSB +: 8];
  wire [3:0] src_w = oper_q[pmath_pkg::OPER_SRC_LSB +: 4];
  wire [15:0] reg_op_w [4];
  wire [15:0] ext_op_w [4];
  assign reg_op_w[0] = ab_q[15:0];
  assign reg_op_w[1] = ab_q[31:16];
  assign reg_op_w[2] = cd_q[15:0];
  assign reg_op_w[3] = cd_q[31:16];
  assign ext_op_w[0] = EXT_OPERAND_IN.first;
  assign ext_op_w[1] = EXT_OPERAND_IN.second;
  assign ext_op_w[2] = EXT_OPERAND_IN.third;
  assign ext_op_w[3] = EXT_OPERAND_IN.fourth;

  // Detector binding and error selection; any number other than UNIT_NUMBER is no unit.
  wire match_w = (watched_unit_number == UNIT_NUMBER);
  function automatic logic hit_f(input logic [1:0] t, input logic z, input logic o);
    case (t)
      pmath_pkg::ERR_ZDIV: hit_f = z;
      pmath_pkg::ERR_OVF: hit_f = o;
      default: hit_f = z | o;
    endcase
  endfunction : hit_f

  // Detector runs at scan start when placed before the unit, at the end when after.
  wire eval_pre_w = go_w & ~det_after_w & DET_EN_IN;
  wire eval_post_w = (state_q == pmath_pkg::S_DONE) & det_after_w & DET_EN_IN;
  wire new_z_w = ran_q ? zacc_q : zdiv_q;
  wire new_o_w = ran_q ? oacc_q : ovf_q;
  wire hit_w = eval_pre_w ? hit_f(etype_w, zdiv_q, ovf_q) : hit_f(etype_w, new_z_w, new_o_w);
  wire eval_w = eval_pre_w | eval_post_w;
  logic flag_d;
  always_comb begin
    if (!match_w) begin
      flag_d = 1'b0;
    end else if (eval_w && auto_w) begin
      flag_d = hit_w;
    end else if (eval_w) begin
      flag_d = hit_w | (flag_q & ~DET_CLR_IN);
    end else begin
      flag_d = flag_q & ~DET_CLR_IN;
    end
  end

  // One operation per step: the operator whose priority equals the step runs.
  logic [1:0] idx, lo, hi, opc;
  logic signed [32:0] a, b, w, q, r, ra, ba;
  logic signed [15:0] res;
  logic zd, ovp, ovn;
  always_comb begin
    idx = 2'd0;
    for (int i = 0; i < 3; i++) begin
      if (oper_q[pmath_pkg::OPER_PRIO_LSB + 2*i +: 2] == step_q) begin
        idx = 2'(i);
      end
    end
    opc = oper_q[pmath_pkg::OPER_OP_LSB + 2*idx +: 2];
    a = 33'(val_q[idx]);
    b = 33'(val_q[idx + 2'd1]);
    zd = 1'b0;
    q = a / ((b == 33'sd0) ? 33'sd1 : b);
    r = a % ((b == 33'sd0) ? 33'sd1 : b);
    ra = r[32] ? -r : r;
    ba = b[32] ? -b : b;
    case (opc)
      pmath_pkg::OP_ADD: w = a + b;
      pmath_pkg::OP_SUB: w = a - b;
      pmath_pkg::OP_MUL: w = a * b;
      pmath_pkg::OP_DIV: begin
        if (b == 33'sd0) begin
          zd = 1'b1;
          w = pmath_pkg::LIM_POS;
        end else if ((ra <<< 1) >= ba) begin
          w = (a[32] ^ b[32]) ? q - 33'sd1 : q + 33'sd1;
        end else begin
          w = q;
        end
      end
      default: w = a;
    endcase
    // Saturate each sub-result so later steps never see a wrapped value.
    ovp = (w > pmath_pkg::LIM_POS);
    ovn = (w < pmath_pkg::LIM_NEG);
    if (ovp) begin
      res = pmath_pkg::SAT_POS;
    end else if (ovn) begin
      res = pmath_pkg::SAT_NEG;
    end else begin
      res = w[15:0];
    end
    // Find the slots already merged with both neighbours of this operator.
    lo = idx;
    hi = idx + 2'd1;
    for (int j = 2; j >= 0; j--) begin
      if (j < int'(idx) && done_q[j] && int'(lo) == j + 1) begin
        lo = 2'(j);
      end
    end
    for (int j = 0; j < 3; j++) begin
      if (j > int'(idx) && done_q[j] && int'(hi) == j) begin
        hi = 2'(j + 1);
      end
    end
  end

  // Scan sequencer: load operands, three steps, then commit.
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_q <= pmath_pkg::S_IDLE;
      step_q <= 2'd0;
      ran_q <= 1'b0;
    end else begin
      case (state_q)
        pmath_pkg::S_IDLE: begin
          if (go_w) begin
            state_q <= EN_IN ? pmath_pkg::S_STEP : pmath_pkg::S_DONE;
            ran_q <= EN_IN;
            step_q <= 2'd0;
          end
        end
        pmath_pkg::S_STEP: begin
          step_q <= step_q + 2'd1;
          if (step_q == 2'd2) begin
            state_q <= pmath_pkg::S_DONE;
          end
        end
        pmath_pkg::S_DONE: state_q <= pmath_pkg::S_IDLE;
        default: state_q <= pmath_pkg::S_IDLE;
      endcase
    end
  end

  // Working operands; every slot of a merged group carries the group's value.
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int j = 0; j < 4; j++) val_q[j] <= 16'sh0000;
      done_q <= 3'b000;
      zacc_q <= 1'b0;
      oacc_q <= 1'b0;
    end else if (go_w) begin
      for (int j = 0; j < 4; j++) begin
        val_q[j] <= src_w[j] ? ext_op_w[j] : reg_op_w[j];
      end
      done_q <= 3'b000;
      zacc_q <= 1'b0;
      oacc_q <= 1'b0;
    end else if (state_q == pmath_pkg::S_STEP) begin
      for (int j = 0; j < 4; j++) begin
        if (j >= int'(lo) && j <= int'(hi)) val_q[j] <= res;
      end
      done_q[idx] <= 1'b1;
      zacc_q <= zacc_q | zd;
      oacc_q <= oacc_q | ovp | ovn;
    end
  end

  // Commit: result, status bits and detector flag.
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      result_q <= 16'sh0000;
      zdiv_q <= 1'b0;
      ovf_q <= 1'b0;
    end else if (state_q == pmath_pkg::S_DONE && ran_q) begin
      result_q <= zacc_q ? pmath_pkg::SAT_POS : val_q[0];
      zdiv_q <= zacc_q;
      ovf_q <= oacc_q;
    end else if (state_q == pmath_pkg::S_DONE && clr_off_w) begin
      result_q <= 16'sh0000;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Interrupt status: hardware set wins over a clear in the same cycle.
  wire [pmath_pkg::IRQ_W-1:0] iset_w = {flag_d & ~flag_q,
    (state_q == pmath_pkg::S_DONE) & ran_q & oacc_q,
    (state_q == pmath_pkg::S_DONE) & ran_q & zacc_q,
    (state_q == pmath_pkg::S_DONE)};
  wire [pmath_pkg::IRQ_W-1:0] iclr_w = (wr_now_w && waddr_q == pmath_pkg::OFF_IRQ_CLR) ?
    HWDATA_IN[pmath_pkg::IRQ_W-1:0] : '0;
  assign ists_d = iset_w | (ists_q & ~iclr_w);

  // Register writes land in the data phase; address is captured in the address phase.
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl_q <= pmath_pkg::CTRL_RST;
      oper_q <= pmath_pkg::OPER_RST;
      ab_q <= pmath_pkg::VAL_RST;
      cd_q <= pmath_pkg::VAL_RST;
      ien_q <= '0;
      ists_q <= '0;
      wr_pend_q <= 1'b0;
      waddr_q <= 8'h00;
    end else begin
      ists_q <= ists_d;
      wr_pend_q <= active_w & HWRITE_IN;
      waddr_q <= raddr_w;
      if (wr_now_w) begin
        case (waddr_q)
          pmath_pkg::OFF_CTRL: ctrl_q <= HWDATA_IN & ~(32'h1 << pmath_pkg::CTRL_SCAN_BIT);
          pmath_pkg::OFF_OPER: oper_q <= HWDATA_IN;
          pmath_pkg::OFF_VAL_AB: ab_q <= HWDATA_IN;
          pmath_pkg::OFF_VAL_CD: cd_q <= HWDATA_IN;
          pmath_pkg::OFF_IRQ_EN: ien_q <= HWDATA_IN[pmath_pkg::IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // Read data is latched at the end of the address phase; a write still in its
  // data phase to the same word, other than the result, interrupt status and clear words, is forwarded so back-to-back access reads new data.
  wire [31:0] res_word_w = {12'h000, state_q != pmath_pkg::S_IDLE, flag_q, ovf_q, zdiv_q,
                            result_q};
  logic [31:0] rmux;
  always_comb begin
    case (raddr_w)
      pmath_pkg::OFF_CTRL: rmux = ctrl_q;
      pmath_pkg::OFF_OPER: rmux = oper_q;
      pmath_pkg::OFF_VAL_AB: rmux = ab_q;
      pmath_pkg::OFF_VAL_CD: rmux = cd_q;
      pmath_pkg::OFF_RESULT: rmux = res_word_w;
      pmath_pkg::OFF_IRQ_STAT: rmux = {28'h0000000, ists_q};
      pmath_pkg::OFF_IRQ_EN: rmux = {28'h0000000, ien_q};
      default: rmux = 32'h0000_0000;
    endcase
  end
  wire fwd_ok_w = fwd_w & (raddr_w != pmath_pkg::OFF_RESULT) &
                  (raddr_w != pmath_pkg::OFF_IRQ_STAT) & (raddr_w != pmath_pkg::OFF_IRQ_CLR);

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      if (active_w & ~HWRITE_IN) rdata_q <= fwd_ok_w ? HWDATA_IN : rmux;
      irq_q <= |(ists_q & ien_q);
    end
  end

  assign HRDATA_OUT = rdata_q;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;
  assign MATH_RESULT_OUT = result_q;
  assign ERR_FLAG_OUT = flag_q;
  assign IRQ_OUT = irq_q;

  // Checks on the datapath and detector.
  AST_ZDIV_SAT: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    (state_q == pmath_pkg::S_DONE && ran_q && zacc_q) |=> result_q == pmath_pkg::SAT_POS)
    else $error("Zero division did not saturate high.");
  AST_NEG_SAT: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    (state_q == pmath_pkg::S_STEP && ovn) |=> (oacc_q && val_q[$past(idx)] == pmath_pkg::SAT_NEG))
    else $error("Underflow did not saturate low.");
  AST_HOLD_OFF: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    (state_q == pmath_pkg::S_DONE && !ran_q && !clr_off_w) |=> $stable(result_q))
    else $error("Disabled result did not hold.");
  AST_CLEAR_OFF: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    (state_q == pmath_pkg::S_DONE && !ran_q && clr_off_w) |=> result_q == 16'sh0000)
    else $error("Disabled result did not clear.");
  AST_THREE_STEPS: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    (go_w && EN_IN) |=> (state_q == pmath_pkg::S_STEP) [*3] ##1 state_q == pmath_pkg::S_DONE)
    else $error("Execution did not take three steps.");
  AST_BITS: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    (state_q == pmath_pkg::S_DONE && ran_q) |=> (zdiv_q == $past(zacc_q) && ovf_q == $past(oacc_q)))
    else $error("Status bits not updated.");
  AST_NULL_LOW: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    !match_w |=> !flag_q)
    else $error("Flag high without a referenced unit.");
  AST_LATCH: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    (flag_q && !auto_w && match_w && !DET_CLR_IN) |=> flag_q)
    else $error("Latched flag dropped without clear.");
  AST_AUTO: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    (eval_w && auto_w && match_w && !hit_w) |=> !flag_q)
    else $error("Auto reset flag did not clear.");
  AST_SAME_SCAN: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    (eval_post_w && ran_q && match_w && zacc_q && etype_w != pmath_pkg::ERR_OVF) |=> flag_q)
    else $error("Error not seen in the same scan.");

  COV_ZDIV: cover property (@(posedge CLOCK_IN) disable iff (RST_IN)
    state_q == pmath_pkg::S_DONE && ran_q && zacc_q);
  COV_OVF: cover property (@(posedge CLOCK_IN) disable iff (RST_IN)
    state_q == pmath_pkg::S_DONE && ran_q && oacc_q);
  COV_FLAG: cover property (@(posedge CLOCK_IN) disable iff (RST_IN) !flag_q ##1 flag_q);
  COV_OFF: cover property (@(posedge CLOCK_IN) disable iff (RST_IN)
    state_q == pmath_pkg::S_DONE && !ran_q);
  COV_PRE: cover property (@(posedge CLOCK_IN) disable iff (RST_IN)
    eval_pre_w && match_w && hit_w);
  // A detector placed before the unit must act on the previous scan's bits at once.
  AST_PRE_SEEN: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    (eval_pre_w && match_w && hit_f(etype_w, zdiv_q, ovf_q)) |=> flag_q)
    else $error("Previous scan error not seen at scan start.");

endmodule : pmath_top

`default_nettype wire

// ---- tb/pmath_far_blocks.sv ----
`timescale 1ns/1ps
`default_nettype none
// Stands in for the program blocks that feed operand values and the scan pulse.
module pmath_far_blocks (
  input wire logic clk_in,
  output var logic scan_out,
  output var pmath_pkg::operands_s vals_out
);
  // Quiet lines at time zero.
  initial begin
    scan_out = 1'b0;
    vals_out = '0;
  end
  // Values stand only for the take edge; an inverted copy follows so a late sample shows.
  task automatic fire(input pmath_pkg::operands_s v);
    @(posedge clk_in);
    scan_out <= 1'b1;
    vals_out <= v;
    @(posedge clk_in);
    scan_out <= 1'b0;
    vals_out <= ~v;
  endtask : fire
endmodule : pmath_far_blocks
`default_nettype wire

// ---- tb/prioritized_math_with_error_detect_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module prioritized_math_with_error_detect_tb_top;
  logic clk, rst, hsel, hwrite, hrdy, hresp, en, det_en, det_clr, scan, flag, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, ctrl_v;
  logic [15:0] res;
  logic [17:0] exp_v;
  pmath_pkg::operands_s ext;
  int failures = 0;
  int n_checks = 0;
  // Operator words; every row gives each priority level to exactly one slot.
  logic [31:0] opr [10] = '{32'h0000_211C, 32'h0000_0608, 32'h0000_180D, 32'h0000_2403,
    32'h0000_2403, 32'h0000_2402, 32'h0000_2402, 32'h0000_2403, 32'h0000_2406,
    32'h0003_211C};
  int vv [10][4] = '{'{12, 6, 3, 1}, '{2, 3, 1, 4}, '{100, 25, 2, 1}, '{7, 2, 0, 0},
    '{-7, 2, 0, 0}, '{200, 200, 0, 0}, '{-200, 200, 0, 0}, '{5, 0, 0, 0},
    '{200, 200, 32767, 0}, '{12, 6, 3, 1}};

  pmath_top dut_u (
    .CLOCK_IN(clk),
    .RST_IN(rst),
    .HSEL_IN(hsel),
    .HADDR_IN(haddr),
    .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite),
    .HSIZE_IN(hsize),
    .HWDATA_IN(hwdata),
    .HREADY_IN(hrdy),
    .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hrdy),
    .HRESP_OUT(hresp),
    .EN_IN(en),
    .SCAN_IN(scan),
    .EXT_OPERAND_IN(ext),
    .DET_EN_IN(det_en),
    .DET_CLR_IN(det_clr),
    .MATH_RESULT_OUT(res),
    .ERR_FLAG_OUT(flag),
    .IRQ_OUT(irq)
  );
  pmath_far_blocks far_u (.clk_in(clk), .scan_out(scan), .vals_out(ext));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Waits for hready under a bound so a stuck slave ends the run.
  task automatic rdy;
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      tally_and_finish();
    end
  endtask : rdy

  // One single word transfer; entered at a rising edge, read data lands in rd.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    hsel <= 1'b1;
    rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask : bus

  // Polls the busy bit; the last read leaves the result word in rd.
  task automatic idle;
    int n = 0;
    repeat (2) @(posedge clk);
    do begin
      bus(1'b0, pmath_pkg::OFF_RESULT, 32'h0);
      n++;
    end while (rd[pmath_pkg::RES_BUSY_BIT] !== 1'b0 && n < 20);
    if (n >= 20) begin
      failures++;
      tally_and_finish();
    end
  endtask : idle

  task automatic run;
    bus(1'b1, pmath_pkg::OFF_CTRL, ctrl_v | 32'h0000_0100);
    idle();
  endtask : run

  task automatic go(input int c);
    bus(1'b1, pmath_pkg::OFF_OPER, opr[c]);
    bus(1'b1, pmath_pkg::OFF_VAL_AB, {vv[c][1][15:0], vv[c][0][15:0]});
    bus(1'b1, pmath_pkg::OFF_VAL_CD, {vv[c][3][15:0], vv[c][2][15:0]});
    run();
  endtask : go

  task automatic fchk(input logic e);
    check("flag", {30'h0, flag, rd[18]}, {30'h0, e, e});
  endtask : fchk

  // Reference evaluation: merges neighbour groups in priority order, saturating each step.
  function automatic logic [17:0] model(input logic [31:0] op, input int v [4]);
    int g [4];
    int gv [4];
    int a, b, r, q, m, old;
    logic zd, ov;
    gv = v;
    g = '{0, 1, 2, 3};
    zd = 1'b0;
    ov = 1'b0;
    for (int l = 0; l < 3; l++) begin
      for (int i = 0; i < 3; i++) begin
        if (int'(op[8 + 2 * i +: 2]) == l) begin
          a = gv[g[i]];
          b = gv[g[i + 1]];
          case (op[2 * i +: 2])
            2'h0: r = a + b;
            2'h1: r = a - b;
            2'h2: r = a * b;
            default: begin
              if (b == 0) begin
                zd = 1'b1;
                r = 32767;
              end else begin
                q = a / b;
                m = a - q * b;
                if (2 * (m < 0 ? -m : m) >= (b < 0 ? -b : b)) begin
                  q += ((a < 0) != (b < 0)) ? -1 : 1;
                end
                r = q;
              end
            end
          endcase
          if (r > 32767) begin
            r = 32767;
            ov = 1'b1;
          end
          if (r < -32768) begin
            r = -32768;
            ov = 1'b1;
          end
          old = g[i + 1];
          for (int k = 0; k < 4; k++) begin
            if (g[k] == old) begin
              g[k] = g[i];
            end
          end
          gv[g[i]] = r;
        end
      end
    end
    r = zd ? 32767 : gv[g[0]];
    return {ov, zd, r[15:0]};
  endfunction : model

  // Main sequence.
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    en = 1'b1;
    det_en = 1'b1;
    det_clr = 1'b0;
    ctrl_v = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("ports", {13'h0, res, flag, irq, hresp}, 32'h0);
    for (int i = 0; i < 9; i++) begin
      if (i != 7) begin
        bus(1'b0, 8'(4 * i), 32'h0);
        check("reg", rd, (i == 1) ? pmath_pkg::OPER_RST : 32'h0);
      end
    end
    bus(1'b1, pmath_pkg::OFF_RESULT, 32'hFFFF_FFFF);
    bus(1'b0, pmath_pkg::OFF_RESULT, 32'h0);
    check("ro", rd, 32'h0);
    for (int c = 0; c < 10; c++) begin
      go(c);
      exp_v = model(opr[c], vv[c]);
      check("math", 32'(rd[17:0]), 32'(exp_v));
      check("out", 32'(res), 32'(exp_v[15:0]));
    end
    en <= 1'b0;
    run();
    check("hold", 32'(res), 32'h0000_000D);
    ctrl_v = 32'h1;
    run();
    check("clear", 32'(rd[15:0]), 32'h0);
    en <= 1'b1;
    ctrl_v = 32'h0;
    bus(1'b1, pmath_pkg::OFF_OPER, 32'h00F0_0608);
    far_u.fire('{16'h0004, 16'h0001, 16'h0003, 16'h0002});
    idle();
    check("ext", 32'(rd[15:0]), 32'h0000_0011);
    ctrl_v = 32'h0001_0002;
    go(7);
    fchk(1'b1);
    go(3);
    fchk(1'b1);
    det_clr <= 1'b1;
    @(posedge clk);
    det_clr <= 1'b0;
    repeat (2) @(posedge clk);
    check("clr", 32'(flag), 32'h0);
    for (int t = 0; t < 4; t++) begin
      for (int k = 0; k < 2; k++) begin
        ctrl_v = 32'h0001_0006 | 32'(t << 4);
        go(k ? 5 : 7);
        fchk(t == 0 ? k == 0 : (t == 1 ? k == 1 : 1'b1));
      end
    end
    go(3);
    fchk(1'b0);
    ctrl_v = 32'h0000_0026;
    go(7);
    fchk(1'b0);
    ctrl_v = 32'h0002_0026;
    go(7);
    fchk(1'b0);
    ctrl_v = 32'h0001_0024;
    bus(1'b1, pmath_pkg::OFF_CTRL, ctrl_v);
    go(3);
    fchk(1'b1);
    go(7);
    fchk(1'b0);
    go(3);
    fchk(1'b1);
    ctrl_v = 32'h0;
    bus(1'b1, pmath_pkg::OFF_IRQ_CLR, 32'h0000_000F);
    bus(1'b1, pmath_pkg::OFF_IRQ_EN, 32'h0000_0002);
    go(3);
    check("masked", 32'(irq), 32'h0);
    bus(1'b0, pmath_pkg::OFF_IRQ_STAT, 32'h0);
    check("stat", 32'(rd[1:0]), 32'h1);
    go(7);
    check("irq", 32'(irq), 32'h1);
    bus(1'b1, pmath_pkg::OFF_IRQ_CLR, 32'h0000_000F);
    repeat (3) @(posedge clk);
    check("irqclr", 32'(irq), 32'h0);
    bus(1'b0, pmath_pkg::OFF_IRQ_STAT, 32'h0);
    check("statclr", rd, 32'h0);
    tally_and_finish();
  end
endmodule : prioritized_math_with_error_detect_tb_top
`default_nettype wire
